// File: hpb_pkg.sv
/*
  Shared types and constants of the host processor bus port.
  Assumes a single 10 MHz clock domain; all pin-side signals are
  asynchronous to it and are synchronised inside the port.
*/
package hpb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 10;
  localparam int BYTE_W = 8;
  localparam int HI_W = DATA_W - BYTE_W;
  localparam int CMD_W = 2;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------
  // Bus formats
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HPB_FMT_10 = 2'h0,
    HPB_FMT_8P2 = 2'h1,
    HPB_FMT_8 = 2'h2
  } hpb_fmt_t;

  // Pin bundle as seen from the host side
  typedef struct packed {
    logic sel_n;
    logic rd_wr_n;
    logic [CMD_W-1:0] command_select;
    logic [DATA_W-1:0] host_data_bus;
  } hpb_pins_t;

  // Write strobe towards the register and palette logic
  typedef struct packed {
    logic valid;
    logic [CMD_W-1:0] target;
    logic [DATA_W-1:0] data;
  } hpb_wr_t;

  // Read request towards the register and palette logic
  typedef struct packed {
    logic req;
    logic [CMD_W-1:0] target;
  } hpb_rd_t;

  typedef enum logic [1:0] {
    HPB_XF_IDLE,
    HPB_XF_WRITE,
    HPB_XF_READ
  } hpb_xfer_t;

endpackage

// File: hpb_pin_sync.sv
/*
  Two-flop synchroniser for the whole host pin bundle.
  Assumes pins are asynchronous to clk_i; only the second stage
  is visible to any logic.
*/
`timescale 1ns/100ps
module hpb_pin_sync
  import hpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pins in, synchronised copy out
  input wire hpb_pins_t pins_i,
  output hpb_pins_t pins_o
);

  typedef struct packed {
    hpb_pins_t s1;
    hpb_pins_t s2;
  } hpb_sync_state_t;

  localparam hpb_pins_t PINS_IDLE = '{sel_n: 1'b1, rd_wr_n: 1'b1, default: '0};

  hpb_sync_state_t st_reg;
  hpb_sync_state_t st_next;

  // Shift the bundle through both stages
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins_i;
    st_next.s2 = st_reg.s1;
  end

  // State register, idle strobe level under reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '{s1: PINS_IDLE, s2: PINS_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins_o = st_reg.s2;

endmodule

// File: hpb_host_port.sv
/*
  Device end of the asynchronous host processor bus port: strobe
  edge detection, command capture, write assembly and read drive.
  Assumes the register and palette logic on clk_i answers a read
  request with rd_data_i in the same cycle as rd_o.req.
*/
//
// Overview of operation
// - Write data taken at select rising edge
// - Write when read/write low, select low
// - Read when read/write high, device returns data
// - Command select picks register or palette target
// - Command select sampled at select falling edge
// - Ten-bit bidirectional data bus both ways
// - Formats: 10-bit, 8 plus 2, 8-bit
//
`timescale 1ns/100ps
module hpb_host_port
  import hpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Host pins
  input wire logic sel_n_i,
  input wire logic rd_wr_n_i,
  input wire logic [CMD_W-1:0] command_select_i,
  input wire logic [DATA_W-1:0] host_data_bus_i,
  output logic [DATA_W-1:0] host_data_bus_o,
  output logic host_data_bus_oe_n_o,
  // Configuration
  input wire hpb_fmt_t bus_format_i,
  // Register and palette side
  output hpb_wr_t wr_o,
  output hpb_rd_t rd_o,
  input wire logic [DATA_W-1:0] rd_data_i
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef struct packed {
    hpb_xfer_t state;
    logic sel_prev_n;
    logic [CMD_W-1:0] cmd;
    logic phase;
    logic [BYTE_W-1:0] lo_byte;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] bus_out;
    logic drive;
    hpb_wr_t wr;
    hpb_rd_t rd;
  } hpb_port_state_t;

  // Place a ten-bit word on the bus in the chosen format
  function automatic logic [DATA_W-1:0] fmt_out(input logic [DATA_W-1:0] w,
                                                input hpb_fmt_t f, input logic ph);
    logic [DATA_W-1:0] r;
    r = w;
    unique case (f)
      HPB_FMT_8: r = {{HI_W{1'b0}}, w[DATA_W-1:HI_W]};
      HPB_FMT_8P2: r = ph ? {{BYTE_W{1'b0}}, w[DATA_W-1:BYTE_W]}
                          : {{HI_W{1'b0}}, w[BYTE_W-1:0]};
      default: r = w;
    endcase
    return r;
  endfunction

  hpb_pins_t pins_raw;
  hpb_pins_t pins;
  hpb_port_state_t st_reg;
  hpb_port_state_t st_next;
  logic sel_fall;
  logic sel_rise;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  assign pins_raw = '{sel_n: sel_n_i, rd_wr_n: rd_wr_n_i,
                      command_select: command_select_i,
                      host_data_bus: host_data_bus_i};

  hpb_pin_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pins_i(pins_raw),
    .pins_o(pins)
  );

  // Edges of the synchronised select strobe
  assign sel_fall = st_reg.sel_prev_n && !pins.sel_n;
  assign sel_rise = !st_reg.sel_prev_n && pins.sel_n;

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sel_prev_n = pins.sel_n;
    st_next.wr.valid = 1'b0;
    st_next.rd.req = 1'b0;
    unique case (st_reg.state)
      HPB_XF_IDLE: begin
        if (sel_fall) begin
          st_next.cmd = pins.command_select;
          if (pins.rd_wr_n) begin
            // read starts, fetch or reuse word
            st_next.state = HPB_XF_READ;
            if (bus_format_i == HPB_FMT_8P2 && st_reg.phase) begin
              st_next.bus_out = fmt_out(st_reg.rd_word, bus_format_i, 1'b1);
              st_next.drive = 1'b1;
            end else begin
              st_next.rd = '{req: 1'b1, target: pins.command_select};
            end
          end else begin
            st_next.state = HPB_XF_WRITE;
          end
        end
      end
      HPB_XF_WRITE: begin
        // data held until rising edge, taken there
        if (sel_rise) begin
          st_next.state = HPB_XF_IDLE;
          unique case (bus_format_i)
            HPB_FMT_8P2: begin
              if (st_reg.phase) begin
                st_next.wr.valid = 1'b1;
                st_next.wr.data = {pins.host_data_bus[HI_W-1:0], st_reg.lo_byte};
              end else begin
                st_next.lo_byte = pins.host_data_bus[BYTE_W-1:0];
              end
              st_next.phase = !st_reg.phase;
            end
            HPB_FMT_8: begin
              st_next.wr.valid = 1'b1;
              st_next.wr.data = {pins.host_data_bus[BYTE_W-1:0], {HI_W{1'b0}}};
            end
            default: begin
              st_next.wr.valid = 1'b1;
              st_next.wr.data = pins.host_data_bus;
            end
          endcase
          st_next.wr.target = st_reg.cmd;
        end
      end
      HPB_XF_READ: begin
        if (st_reg.rd.req) begin
          st_next.rd_word = rd_data_i;
          st_next.bus_out = fmt_out(rd_data_i, bus_format_i, 1'b0);
          st_next.drive = 1'b1;
        end
        if (sel_rise) begin
          // release bus when select returns high
          st_next.state = HPB_XF_IDLE;
          st_next.drive = 1'b0;
          if (bus_format_i == HPB_FMT_8P2) begin
            st_next.phase = !st_reg.phase;
          end
        end
      end
      default: begin
        st_next.state = HPB_XF_IDLE;
        st_next.drive = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '{state: HPB_XF_IDLE, sel_prev_n: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_data_bus_o = st_reg.bus_out;
  assign host_data_bus_oe_n_o = !st_reg.drive;
  assign wr_o = st_reg.wr;
  assign rd_o = st_reg.rd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_drive_only_read:
    assert property (!host_data_bus_oe_n_o |-> st_reg.state == HPB_XF_READ)
    else $error("data bus driven outside a read");

  a_release_after_rise:
    assert property (st_reg.state == HPB_XF_READ && sel_rise |=> host_data_bus_oe_n_o)
    else $error("data bus not released after select rose");

  a_cmd_at_fall:
    assert property (sel_fall |=> st_reg.cmd == $past(pins.command_select))
    else $error("command not latched at falling edge");

  a_write_on_rise:
    assert property (wr_o.valid |-> $past(sel_rise) && $past(st_reg.state) == HPB_XF_WRITE)
    else $error("write strobe without select rising edge");

  a_write_one_pulse:
    assert property (wr_o.valid |=> !wr_o.valid)
    else $error("write strobe longer than one cycle");

  a_read_req_dir:
    assert property (sel_fall && pins.rd_wr_n && !(bus_format_i == HPB_FMT_8P2 && st_reg.phase)
                     |=> rd_o.req ##1 !host_data_bus_oe_n_o)
    else $error("read request or drive missing");

  a_target_is_cmd:
    assert property (wr_o.valid |-> wr_o.target == $past(st_reg.cmd))
    else $error("write target differs from latched command");

  a_ten_bit_read:
    assert property (rd_o.req && bus_format_i == HPB_FMT_10 |=> host_data_bus_o == $past(rd_data_i))
    else $error("ten-bit read word not placed on bus");

  a_byte_pad_low:
    assert property (wr_o.valid && $past(bus_format_i) == HPB_FMT_8 |-> wr_o.data[HI_W-1:0] == '0)
    else $error("eight-bit write not padded in low bits");

endmodule

// File: hpb_host_model.sv
/*
  Host processor model: drives select, direction, command and data.
  Assumes one clock; bus wire resolved from the device output enable.
*/
`timescale 1ns/100ps
module hpb_host_model
  import hpb_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Device side of the wire
  input wire logic [DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_n_i,
  // Pins towards the device
  output logic sel_n_o,
  output logic rd_wr_n_o,
  output logic [CMD_W-1:0] cmd_o,
  output logic [DATA_W-1:0] bus_o
);
  logic [DATA_W-1:0] drv = '0;
  logic [DATA_W-1:0] flt = '0;
  logic drv_en = 1'b0;
  initial begin
    sel_n_o = 1'b1;
    rd_wr_n_o = 1'b1;
    cmd_o = '0;
  end
  // A released wire shows a pattern that changes every cycle
  always @(posedge clk_i) flt <= ~flt;
  // host owns the wire in writes
  assign bus_o = !dev_oe_n_i ? dev_data_i : (drv_en ? drv : flt);
  // One transfer; command and data change late, data held past the rise
  task automatic xfer(input logic rd, input logic [1:0] c, input logic [9:0] d,
                      output logic [9:0] q);
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    rd_wr_n_o <= rd;
    cmd_o <= c;
    drv_en <= !rd;
    drv <= ~d;
    repeat (4) @(posedge clk_i);
    cmd_o <= ~c;
    drv <= d;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) q = bus_o;
    @(posedge clk_i);
    sel_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    drv_en <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// File: host_processor_bus_port_test.sv
/*
  Self-checking bench of the host port: host model on the pins,
  a fixed-table register side answering read requests.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module host_processor_bus_port_test;
  import hpb_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  hpb_fmt_t fmt = HPB_FMT_10;
  logic sel_n, rw, oe_n;
  logic [1:0] cmd;
  logic [9:0] bus, dev_o, rd_data, q, q2;
  hpb_wr_t wr;
  hpb_rd_t rd;
  int error_cnt = 0;
  int checked = 0;
  int wr_cnt = 0;
  hpb_wr_t wr_last;
  initial forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  // Register side content per target
  function automatic logic [9:0] word(input logic [1:0] c);
    return {c, 4'h9, c, ~c};
  endfunction
  assign rd_data = word(rd.target);
  // Count write strobes
  always @(posedge clk_i) if (wr.valid === 1'b1) begin
    wr_cnt <= wr_cnt + 1;
    wr_last <= wr;
  end
  hpb_host_model host (.clk_i(clk_i), .dev_data_i(dev_o), .dev_oe_n_i(oe_n),
    .sel_n_o(sel_n), .rd_wr_n_o(rw), .cmd_o(cmd), .bus_o(bus));
  hpb_host_port DUT (.clk_i(clk_i), .srst_i(srst_i), .sel_n_i(sel_n), .rd_wr_n_i(rw),
    .command_select_i(cmd), .host_data_bus_i(bus), .host_data_bus_o(dev_o),
    .host_data_bus_oe_n_o(oe_n), .bus_format_i(fmt), .wr_o(wr), .rd_o(rd),
    .rd_data_i(rd_data));
  // Wait for the strobe count to reach n; count taken before the transfer
  task automatic wait_wr(input int n);
    for (int i = 0; i < 20 && wr_cnt < n; i++) @(posedge clk_i);
    `CHK("wr count", n, wr_cnt)
  endtask
  // Ten-bit writes to every target
  task automatic t_write10;
    logic [9:0] d;
    int n;
    for (int c = 0; c < 4; c++) begin
      d = {c[1:0], ~{4{c[1:0]}}};
      n = wr_cnt;
      host.xfer(1'b0, c[1:0], d, q);
      wait_wr(n + 1);
      `CHK("wr target", c[1:0], wr_last.target)
      `CHK("wr data", d, wr_last.data)
      `CHK("oe_n on write", 1'b1, oe_n)
    end
  endtask
  // Ten-bit reads from every target
  task automatic t_read10;
    int n;
    n = wr_cnt;
    for (int c = 0; c < 4; c++) begin
      host.xfer(1'b1, c[1:0], 10'h000, q);
      `CHK("rd data", word(c[1:0]), q)
      `CHK("oe_n after rd", 1'b1, oe_n)
    end
    `CHK("no wr on rd", n, wr_cnt)
  endtask
  // Plain 8-bit write and read
  task automatic t_fmt8;
    int n;
    fmt <= HPB_FMT_8;
    n = wr_cnt;
    host.xfer(1'b0, 2'h1, 10'h0C3, q);
    wait_wr(n + 1);
    `CHK("8b wr data", 10'h30C, wr_last.data)
    host.xfer(1'b1, 2'h2, 10'h000, q);
    `CHK("8b rd data", word(2'h2) >> 2, {2'h0, q[7:0]})
  endtask
  // Split 8+2 write and read; a mid-run reset drops a half-done pair
  task automatic t_fmt82;
    int n;
    fmt <= HPB_FMT_8P2;
    n = wr_cnt;
    host.xfer(1'b0, 2'h0, 10'h3FF, q);
    `CHK("8+2 half pair", n, wr_cnt)
    @(posedge clk_i) srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    host.xfer(1'b0, 2'h3, 10'h0E7, q);
    `CHK("8+2 no early wr", n, wr_cnt)
    host.xfer(1'b0, 2'h3, 10'h002, q);
    wait_wr(n + 1);
    `CHK("8+2 wr data", 10'h2E7, wr_last.data)
    `CHK("8+2 wr target", 2'h3, wr_last.target)
    host.xfer(1'b1, 2'h1, 10'h000, q);
    // Second half reuses the first word, whatever its command
    host.xfer(1'b1, 2'h2, 10'h000, q2);
    `CHK("8+2 rd lo", word(2'h1) & 10'h0FF, {2'h0, q[7:0]})
    `CHK("8+2 rd hi", word(2'h1) >> 8, {8'h00, q2[1:0]})
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    t_write10;
    t_read10;
    t_fmt8;
    t_fmt82;
    report_and_stop;
  end
  // Watchdog: some 15 transfers of 14 cycles each, with a wide margin
  initial begin
    #(2000 * CLK_PERIOD_NS);
    error_cnt++;
    report_and_stop;
  end
endmodule
